// File: dv/serial_rx_chk.sv
// handshake and reset checks on the serial receiver ports
`timescale 1ns/1ns
`default_nettype none
module serial_rx_chk (
	// clock and reset
	input wire logic        aclk,
	input wire logic        aresetn,
	// write channels
	input wire logic        s_axi_awvalid,
	input wire logic        s_axi_awready,
	input wire logic        s_axi_wvalid,
	input wire logic        s_axi_wready,
	input wire logic [1:0]  s_axi_bresp,
	input wire logic        s_axi_bvalid,
	input wire logic        s_axi_bready,
	// read channels
	input wire logic        s_axi_arvalid,
	input wire logic        s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic        s_axi_rvalid,
	input wire logic        s_axi_rready,
	// line and interrupt
	input wire logic        serial_output_pin,
	input wire logic        irq
);
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	// reset is checked with its own disable, it is the antecedent itself
	a_reset_quiet: assert property (@(posedge aclk) disable iff (1'b0)
		!aresetn |=> !s_axi_awready && !s_axi_arready && !s_axi_bvalid
		&& !s_axi_rvalid && !irq && serial_output_pin)
		else $error("outputs not quiet after reset");
	// write answer comes exactly two edges after both halves are taken
	a_write_answer: assert property (s_axi_awvalid && s_axi_awready
		&& s_axi_wvalid && s_axi_wready |=> !s_axi_bvalid ##1 s_axi_bvalid)
		else $error("write response not on time");
	a_bresp_held: assert property (s_axi_bvalid && !s_axi_bready
		|=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped early");
	a_write_refused: assert property (s_axi_bvalid |->
		!s_axi_awready && !s_axi_wready)
		else $error("write taken while response pending");
	a_ready_return: assert property (s_axi_bvalid && s_axi_bready
		|=> !s_axi_bvalid ##[0:1] s_axi_awready)
		else $error("write ready not restored");
	a_aw_drop: assert property (s_axi_awvalid && s_axi_awready
		|=> !s_axi_awready)
		else $error("write address ready stuck high");
	a_read_answer: assert property (s_axi_arvalid && s_axi_arready
		|=> s_axi_rvalid && !s_axi_arready)
		else $error("read data not one cycle after address");
	a_rdata_held: assert property (s_axi_rvalid && !s_axi_rready
		|=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data changed before taken");
	// main scenarios reached
	c_read: cover property (s_axi_rvalid && s_axi_rready);
	c_write: cover property (s_axi_bvalid && s_axi_bready);
	c_irq: cover property ($rose(irq));
endmodule // serial_rx_chk
bind async_serial_receiver serial_rx_chk i_chk (.aclk(aclk),
	.aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid),
	.s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
	.s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
	.s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
	.s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
	.s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid),
	.s_axi_rready(s_axi_rready), .serial_output_pin(serial_output_pin),
	.irq(irq));
`default_nettype wire

// File: dv/serial_tx_model.sv
// remote serial transmitter that drives the receiver input line
`timescale 1ns/1ns
`default_nettype none
module serial_tx_model (
	// clock
	input  wire logic aclk,
	// serial line
	output var logic  line
);
	// idle mark level between frames; only this end drives the line,
	// the receiver pin is kept a pure input
	initial line = 1'b1;
	// one frame lsb first; a short start models a glitch on the line
	task automatic send(input logic [7:0] d, input logic stop,
		input int bclk, input int sclk);
		logic [9:0] f;
		f = {stop, d, 1'b0};
		for (int i = 0; i < 10; i++) begin
			for (int c = 0; c < bclk; c++) begin
				@(posedge aclk);
				line <= (i == 0 && c >= sclk) ? 1'b1 : f[i];
			end
		end
		@(posedge aclk);
		line <= 1'b1;
	endtask
endmodule // serial_tx_model
`default_nettype wire

// File: dv/tb_top.sv
// self-checking bench for the serial receiver registers and line
`timescale 1ns/1ns
`default_nettype none
module tb_top;
	logic        aclk, aresetn;
	logic [7:0]  awaddr, araddr;
	logic        awvalid, awready, wvalid, wready, bvalid, bready;
	logic [31:0] wdata, rdata;
	logic [1:0]  bresp, rresp;
	logic        arvalid, arready, rvalid, rready;
	logic        rx_line, tx_line, irq;
	int          failures, compares;
	// bus clock, 50 ns period
	initial aclk = 1'b0;
	always #25 aclk = ~aclk;
	async_serial_receiver i_dut (.aclk(aclk), .aresetn(aresetn),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'h1),
		.s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
		.s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
		.s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready), .serial_input_pin(rx_line),
		.serial_output_pin(tx_line), .irq(irq));
	serial_tx_model i_peer (.aclk(aclk), .line(rx_line));
	// one compare for every result, all widened to a word
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			failures++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic finish_test();
		$display("failures %0d compares %0d", failures, compares);
		if (failures == 0 && compares > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	// a hung handshake ends the run as a mismatch
	task automatic give_up();
		failures++;
		$display("wrong value at %0t: got 0 expected 1 (no answer)", $time);
		finish_test();
	endtask
	// write: address and data offered together, each dropped when taken
	task automatic wr(input logic [7:0] a, input logic [31:0] d,
		input logic [1:0] er = serial_rx_pkg::RESP_OKAY);
		int n;
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		for (n = 0; n < 50; n++) begin
			@(posedge aclk);
			if (awready)
				awvalid <= 1'b0;
			if (wready)
				wvalid <= 1'b0;
			if (bvalid)
				break;
		end
		if (n == 50)
			give_up();
		bready <= 1'b0;
		check(32'(bresp), 32'(er));
	endtask
	// read and compare data and response
	task automatic rd(input logic [7:0] a, input logic [31:0] ed,
		input logic [1:0] er = serial_rx_pkg::RESP_OKAY);
		int n;
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		for (n = 0; n < 50; n++) begin
			@(posedge aclk);
			if (arready)
				arvalid <= 1'b0;
			if (rvalid)
				break;
		end
		if (n == 50)
			give_up();
		rready <= 1'b0;
		check(rdata, ed);
		check(32'(rresp), 32'(er));
	endtask
	// a frame, then a few cycles for the push and the interrupt flop
	task automatic frame(input logic [7:0] d, input logic stop = 1'b1,
		input int bclk = 16, input int sclk = 16);
		i_peer.send(d, stop, bclk, sclk);
		repeat (8) @(posedge aclk);
	endtask
	initial begin
		int n;
		logic [7:0] modes [3];
		modes = '{8'h07, 8'h04, 8'h01};
		failures = 0;
		compares = 0;
		aresetn = 1'b0;
		{awaddr, araddr, wdata} = '0;
		{awvalid, wvalid, bready, arvalid, rready} = '0;
		repeat (5) @(posedge aclk);
		aresetn <= 1'b1;
		// reset values, read-only and unmapped places
		rd(serial_rx_pkg::OFF_RX_DATA, 32'h0);
		rd(serial_rx_pkg::OFF_TX_DATA, 32'h0);
		rd(serial_rx_pkg::OFF_BAUD_LOW, 32'h0);
		wr(serial_rx_pkg::OFF_RX_DATA, 32'h5A, serial_rx_pkg::RESP_SLVERR);
		rd(8'h1C, 32'h0, serial_rx_pkg::RESP_SLVERR);
		wr(serial_rx_pkg::OFF_IRQ_MASK, 32'h7);
		// one control setting per gate condition, each of which must keep the receiver off
		foreach (modes[i]) begin
			wr(serial_rx_pkg::OFF_CONTROL, 32'(modes[i]));
			frame(8'h81);
			rd(serial_rx_pkg::OFF_STATUS, 32'h10);
		end
		wr(serial_rx_pkg::OFF_CONTROL, 32'h05);
		// short start pulse is dropped silently
		frame(8'hFF, 1'b1, 16, 4);
		rd(serial_rx_pkg::OFF_STATUS, 32'h10);
		rd(serial_rx_pkg::OFF_IRQ_STAT, 32'h0);
		// good character at sixteen ticks a bit
		frame(8'hA5);
		check(32'(irq), 32'h1);
		rd(serial_rx_pkg::OFF_IRQ_STAT, 32'h1);
		rd(serial_rx_pkg::OFF_STATUS, 32'h14);
		rd(serial_rx_pkg::OFF_RX_DATA, 32'hA5);
		rd(serial_rx_pkg::OFF_STATUS, 32'h10);
		wr(serial_rx_pkg::OFF_IRQ_STAT, 32'h1);
		rd(serial_rx_pkg::OFF_IRQ_STAT, 32'h0);
		check(32'(irq), 32'h0);
		// low stop bit marks this character only
		frame(8'h3C, 1'b0);
		rd(serial_rx_pkg::OFF_STATUS, 32'h16);
		rd(serial_rx_pkg::OFF_IRQ_STAT, 32'h5);
		rd(serial_rx_pkg::OFF_RX_DATA, 32'h3C);
		frame(8'hC3);
		rd(serial_rx_pkg::OFF_STATUS, 32'h14);
		rd(serial_rx_pkg::OFF_RX_DATA, 32'hC3);
		wr(serial_rx_pkg::OFF_IRQ_STAT, 32'h7);
		// two held, third overruns and is lost
		frame(8'h11);
		frame(8'h22);
		frame(8'h33);
		rd(serial_rx_pkg::OFF_STATUS, 32'h1C);
		rd(serial_rx_pkg::OFF_IRQ_STAT, 32'h3);
		rd(serial_rx_pkg::OFF_RX_DATA, 32'h11);
		rd(serial_rx_pkg::OFF_RX_DATA, 32'h22);
		frame(8'h44);
		rd(serial_rx_pkg::OFF_STATUS, 32'h18);
		wr(serial_rx_pkg::OFF_IRQ_STAT, 32'h2);
		frame(8'h55);
		// old character readable while the next arrives
		fork
			frame(8'h66);
			begin
				repeat (60) @(posedge aclk);
				rd(serial_rx_pkg::OFF_RX_DATA, 32'h55);
			end
		join
		rd(serial_rx_pkg::OFF_RX_DATA, 32'h66);
		// nine data bits: the high stop argument is the ninth bit,
		// the idle line after the frame is the stop bit
		wr(serial_rx_pkg::OFF_CONTROL, 32'h15);
		frame(8'hC9);
		repeat (16) @(posedge aclk);
		rd(serial_rx_pkg::OFF_STATUS, 32'h15);
		rd(serial_rx_pkg::OFF_RX_DATA, 32'hC9);
		wr(serial_rx_pkg::OFF_CONTROL, 32'h05);
		// new divisor restarts the tick counter, bit becomes 32 clocks
		wr(serial_rx_pkg::OFF_BAUD_LOW, 32'h1);
		rd(serial_rx_pkg::OFF_BAUD_LOW, 32'h1);
		frame(8'h5A, 1'b1, 32, 32);
		rd(serial_rx_pkg::OFF_RX_DATA, 32'h5A);
		// transmit holding buffer frees once shifting starts
		wr(serial_rx_pkg::OFF_TX_DATA, 32'h96);
		for (n = 0; n < 200 && tx_line; n++)
			@(posedge aclk);
		check(32'(tx_line), 32'h0);
		wr(serial_rx_pkg::OFF_TX_DATA, 32'h69);
		wr(serial_rx_pkg::OFF_TX_DATA, 32'h77, serial_rx_pkg::RESP_SLVERR);
		rd(serial_rx_pkg::OFF_TX_DATA, 32'h69);
		// shifter busy, buffer full; stale head is the nine-bit char
		rd(serial_rx_pkg::OFF_STATUS, 32'h21);
		finish_test();
	end
endmodule // tb_top
`default_nettype wire

// File: rtl/async_serial_receiver.sv
// asynchronous serial receiver with axi4-lite registers
//
// Behaviour
// - recovery runs on 16x baud ticks; shift register advances once per bit
// - finished character goes at once into a two-entry fifo
// - receive only when continuous enable 1, clocked mode 0, port enable 1
// - a falling edge on the serial input starts a character
// - half a bit later line must be low, else drop silently, hunt again
// - each data bit sampled one bit time later by majority, shifted in
// - stop bit sampled one bit later; zero sets framing error, one clears
// - after stop bit character enters fifo and receive flag is set
// - reading receive data returns oldest character and removes it
// - after overrun no characters are accepted until overrun is cleared
// - shift register and fifo reachable only via receive data register; status also shows head's ninth bit and error
// - receive data holds low eight bits; ninth bit in a status bit
// - receive data double buffered: readable while next is received
// - transmit data double buffered; writable once previous starts out
// - writing the baud divisor low byte restarts the baud counter
//
// The address map and the AXI4-Lite register port were chosen for this implementation.
`timescale 1ns/1ns
`default_nettype none
module async_serial_receiver (
	// clock and reset
	input  wire logic        aclk,
	input  wire logic        aresetn,
	// axi4-lite write channels
	input  wire logic [7:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	// axi4-lite read channels
	input  wire logic [7:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	// serial line and interrupt
	input  wire logic        serial_input_pin,
	output logic             serial_output_pin,
	output logic             irq
);
	// majority of three samples
	function automatic logic majority(input logic [2:0] s);
		majority = (s[0] & s[1]) | (s[0] & s[2]) | (s[1] & s[2]);
	endfunction

	// bus state
	logic                     aw_have_q, aw_have_d, w_have_q, w_have_d;
	logic [7:0]               awaddr_q, awaddr_d;
	logic [31:0]              wdata_q, wdata_d;
	logic                     wlane_q, wlane_d;
	logic                     awready_q, awready_d, wready_q, wready_d;
	logic                     bvalid_q, bvalid_d, arready_q, arready_d;
	logic                     rvalid_q, rvalid_d;
	logic [1:0]               bresp_q, bresp_d, rresp_q, rresp_d;
	logic [31:0]              rdata_q, rdata_d;
	// software registers
	serial_rx_pkg::ctrl_type  ctrl_q, ctrl_d;
	logic [7:0]               div_q, div_d, txhold_q, txhold_d;
	logic                     txfull_q, txfull_d, tx9hold_q, tx9hold_d;
	logic [2:0]               ist_q, ist_d, imask_q, imask_d;
	logic                     irq_q, irq_d;
	// strobes from the bus to the datapath
	logic                     pop, div_wr, ovr_clr;
	// baud tick generator
	logic [7:0]               brg_q, brg_d;
	logic                     tick_q, tick_d;
	// receiver
	serial_rx_pkg::rx_state_type st_q, st_d;
	logic [3:0]               cnt_q, cnt_d, bitn_q, bitn_d;
	logic [2:0]               samp_q, samp_d;
	logic [8:0]               rsr_q, rsr_d;
	logic                     line_q, line_d, maj, rx_active;
	logic                     push;
	serial_rx_pkg::rx_char_type pchar;
	// fifo
	serial_rx_pkg::rx_char_type mem_q [2];
	serial_rx_pkg::rx_char_type mem_d [2];
	logic                     wp_q, wp_d, rp_q, rp_d, ovr_q, ovr_d;
	logic [1:0]               fcnt_q, fcnt_d;
	logic                     accept;
	// transmitter
	logic [10:0]              tsh_q, tsh_d;
	logic [3:0]               tcnt_q, tcnt_d, tbits_q, tbits_d;
	logic                     tbusy_q, tbusy_d, txo_q, txo_d, tx_load;

	assign s_axi_awready     = awready_q;
	assign s_axi_wready      = wready_q;
	assign s_axi_bvalid      = bvalid_q;
	assign s_axi_bresp       = bresp_q;
	assign s_axi_arready     = arready_q;
	assign s_axi_rvalid      = rvalid_q;
	assign s_axi_rresp       = rresp_q;
	assign s_axi_rdata       = rdata_q;
	assign serial_output_pin = txo_q;
	assign irq               = irq_q;

	// reception gate; fifo push is refused while overrun stands
	assign rx_active = ctrl_q.continuous_receive_enable
		& ~ctrl_q.clocked_mode_select
		& ctrl_q.serial_port_enable;
	assign accept    = push & (fcnt_q != 2'h2) & ~ovr_q;
	assign tx_load   = txfull_q & ~tbusy_q & ctrl_q.serial_port_enable;

	// bus slave and software registers
	always_comb begin
		aw_have_d = aw_have_q;
		w_have_d  = w_have_q;
		awaddr_d  = awaddr_q;
		wdata_d   = wdata_q;
		wlane_d   = wlane_q;
		bvalid_d  = bvalid_q;
		bresp_d   = bresp_q;
		arready_d = arready_q;
		rvalid_d  = rvalid_q;
		rresp_d   = rresp_q;
		rdata_d   = rdata_q;
		ctrl_d    = ctrl_q;
		div_d     = div_q;
		txhold_d  = txhold_q;
		tx9hold_d = tx9hold_q;
		txfull_d  = txfull_q & ~tx_load;
		imask_d   = imask_q;
		pop       = 1'b0;
		div_wr    = 1'b0;
		ovr_clr   = 1'b0;
		ist_d     = ist_q;
		// address and data are taken in either order
		if (s_axi_awvalid && awready_q) begin
			aw_have_d = 1'b1;
			awaddr_d  = s_axi_awaddr;
		end
		if (s_axi_wvalid && wready_q) begin
			w_have_d = 1'b1;
			wdata_d  = s_axi_wdata;
			wlane_d  = s_axi_wstrb[0];
		end
		if (bvalid_q && s_axi_bready)
			bvalid_d = 1'b0;
		if (aw_have_q && w_have_q && !bvalid_q) begin
			aw_have_d = 1'b0;
			w_have_d  = 1'b0;
			bvalid_d  = 1'b1;
			bresp_d   = serial_rx_pkg::RESP_OKAY;
			if (awaddr_q == serial_rx_pkg::OFF_RX_DATA) begin
				bresp_d = serial_rx_pkg::RESP_SLVERR; // read-only
			end else if (awaddr_q == serial_rx_pkg::OFF_TX_DATA) begin
				// a full holding buffer drops the write, reported as error
				if (txfull_q && !tx_load)
					bresp_d = serial_rx_pkg::RESP_SLVERR;
				else if (wlane_q) begin
					txhold_d  = wdata_q[7:0];
					tx9hold_d = ctrl_q.ninth_transmit_bit;
					txfull_d  = 1'b1;
				end
			end else if (awaddr_q == serial_rx_pkg::OFF_BAUD_LOW) begin
				if (wlane_q) begin
					div_d  = wdata_q[7:0];
					div_wr = 1'b1;
				end
			end else if (awaddr_q == serial_rx_pkg::OFF_CONTROL) begin
				if (wlane_q)
					ctrl_d = wdata_q[4:0];
			end else if (awaddr_q == serial_rx_pkg::OFF_STATUS) begin
				bresp_d = serial_rx_pkg::RESP_SLVERR;
			end else if (awaddr_q == serial_rx_pkg::OFF_IRQ_STAT) begin
				if (wlane_q) begin
					ist_d   = ist_q & ~wdata_q[2:0];
					ovr_clr = wdata_q[serial_rx_pkg::IRQ_OVR];
				end
			end else if (awaddr_q == serial_rx_pkg::OFF_IRQ_MASK) begin
				if (wlane_q)
					imask_d = wdata_q[2:0];
			end else begin
				bresp_d = serial_rx_pkg::RESP_SLVERR;
			end
		end
		awready_d = !aw_have_d && !bvalid_d;
		wready_d  = !w_have_d && !bvalid_d;
		// read: one outstanding, answer one cycle after the address
		if (rvalid_q && s_axi_rready) begin
			rvalid_d  = 1'b0;
			arready_d = 1'b1;
		end
		if (s_axi_arvalid && arready_q) begin
			arready_d = 1'b0;
			rvalid_d  = 1'b1;
			rresp_d   = serial_rx_pkg::RESP_OKAY;
			rdata_d   = 32'h0000_0000;
			if (s_axi_araddr == serial_rx_pkg::OFF_RX_DATA) begin
				// only window onto the fifo's data byte; reading removes the head
				rdata_d[7:0] = mem_q[rp_q].data;
				pop          = fcnt_q != 2'h0;
			end else if (s_axi_araddr == serial_rx_pkg::OFF_TX_DATA) begin
				rdata_d[7:0] = txhold_q;
			end else if (s_axi_araddr == serial_rx_pkg::OFF_BAUD_LOW) begin
				rdata_d[7:0] = div_q;
			end else if (s_axi_araddr == serial_rx_pkg::OFF_CONTROL) begin
				rdata_d[4:0] = ctrl_q;
			end else if (s_axi_araddr == serial_rx_pkg::OFF_STATUS) begin
				// head's ninth bit and error: read before receive data
				rdata_d[0] = mem_q[rp_q].ninth_received_bit;
				rdata_d[1] = mem_q[rp_q].framing_error;
				rdata_d[2] = fcnt_q != 2'h0;
				rdata_d[3] = ovr_q;
				rdata_d[4] = !txfull_q;
				rdata_d[5] = tbusy_q;
			end else if (s_axi_araddr == serial_rx_pkg::OFF_IRQ_STAT) begin
				rdata_d[2:0] = ist_q;
			end else if (s_axi_araddr == serial_rx_pkg::OFF_IRQ_MASK) begin
				rdata_d[2:0] = imask_q;
			end else begin
				rresp_d = serial_rx_pkg::RESP_SLVERR;
			end
		end
		// address ready whenever no read answer waits; also lifts it
		// after reset, where the flop comes up low
		arready_d = !rvalid_d;
		// events win over a clear in the same cycle
		if (accept)
			ist_d[serial_rx_pkg::IRQ_RX] = 1'b1;
		if (accept && pchar.framing_error)
			ist_d[serial_rx_pkg::IRQ_FE] = 1'b1;
		if (push && !accept)
			ist_d[serial_rx_pkg::IRQ_OVR] = 1'b1;
		irq_d = |(ist_d & imask_d);
	end

	// bus and register flops
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_have_q <= 1'b0;
			w_have_q  <= 1'b0;
			awaddr_q  <= serial_rx_pkg::BYTE_RESET;
			wdata_q   <= 32'h0000_0000;
			wlane_q   <= 1'b0;
			awready_q <= 1'b0;
			wready_q  <= 1'b0;
			bvalid_q  <= 1'b0;
			bresp_q   <= serial_rx_pkg::RESP_OKAY;
			arready_q <= 1'b0;
			rvalid_q  <= 1'b0;
			rresp_q   <= serial_rx_pkg::RESP_OKAY;
			rdata_q   <= 32'h0000_0000;
			ctrl_q    <= serial_rx_pkg::CTRL_RESET;
			div_q     <= serial_rx_pkg::BYTE_RESET;
			txhold_q  <= serial_rx_pkg::BYTE_RESET;
			tx9hold_q <= 1'b0;
			txfull_q  <= 1'b0;
			ist_q     <= serial_rx_pkg::IRQ_RESET;
			imask_q   <= serial_rx_pkg::IRQ_RESET;
			irq_q     <= 1'b0;
		end else begin
			aw_have_q <= aw_have_d;
			w_have_q  <= w_have_d;
			awaddr_q  <= awaddr_d;
			wdata_q   <= wdata_d;
			wlane_q   <= wlane_d;
			awready_q <= awready_d;
			wready_q  <= wready_d;
			bvalid_q  <= bvalid_d;
			bresp_q   <= bresp_d;
			arready_q <= arready_d;
			rvalid_q  <= rvalid_d;
			rresp_q   <= rresp_d;
			rdata_q   <= rdata_d;
			ctrl_q    <= ctrl_d;
			div_q     <= div_d;
			txhold_q  <= txhold_d;
			tx9hold_q <= tx9hold_d;
			txfull_q  <= txfull_d;
			ist_q     <= ist_d;
			imask_q   <= imask_d;
			irq_q     <= irq_d;
		end
	end

	// 16x tick every divisor+1 clocks; restarted by a divisor write
	always_comb begin
		tick_d = 1'b0;
		brg_d  = brg_q + 8'h01;
		if (div_wr) begin
			brg_d = serial_rx_pkg::BYTE_RESET;
		end else if (brg_q >= div_q) begin
			brg_d  = serial_rx_pkg::BYTE_RESET;
			tick_d = 1'b1;
		end
	end

	// receive sequencer: tick count in the bit, majority at centre
	always_comb begin
		st_d   = st_q;
		cnt_d  = cnt_q;
		bitn_d = bitn_q;
		samp_d = samp_q;
		rsr_d  = rsr_q;
		line_d = serial_input_pin;
		push   = 1'b0;
		maj    = majority({samp_q[1:0], serial_input_pin});
		pchar  = serial_rx_pkg::CHAR_RESET;
		if (ctrl_q.nine_bit_mode) begin
			pchar.data               = rsr_q[7:0];
			pchar.ninth_received_bit = rsr_q[8];
		end else begin
			pchar.data = rsr_q[8:1];
		end
		pchar.framing_error = !maj;
		if (tick_q && cnt_q >= serial_rx_pkg::SAMPLE_FIRST
				&& cnt_q <= serial_rx_pkg::SAMPLE_LAST)
			samp_d = {samp_q[1:0], serial_input_pin};
		if (tick_q)
			cnt_d = cnt_q + 4'h1;
		case (st_q)
			serial_rx_pkg::RX_IDLE: begin
				cnt_d = 4'h0;
				// overrun holds the receiver here until it is cleared
				if (line_q && !serial_input_pin && !ovr_q)
					st_d = serial_rx_pkg::RX_START;
			end
			serial_rx_pkg::RX_START: begin
				if (tick_q && cnt_q == serial_rx_pkg::SAMPLE_LAST) begin
					bitn_d = 4'h0;
					// high at half bit: glitch, dropped without error
					st_d = maj ? serial_rx_pkg::RX_IDLE
						: serial_rx_pkg::RX_DATA;
				end
			end
			serial_rx_pkg::RX_DATA: begin
				if (tick_q && cnt_q == serial_rx_pkg::SAMPLE_LAST) begin
					rsr_d  = {maj, rsr_q[8:1]};
					bitn_d = bitn_q + 4'h1;
					if (bitn_q == (ctrl_q.nine_bit_mode
							? serial_rx_pkg::LAST_BIT_9
							: serial_rx_pkg::LAST_BIT_8))
						st_d = serial_rx_pkg::RX_STOP;
				end
			end
			serial_rx_pkg::RX_STOP: begin
				if (tick_q && cnt_q == serial_rx_pkg::SAMPLE_LAST) begin
					push = 1'b1;
					st_d = serial_rx_pkg::RX_IDLE;
				end
			end
			default: st_d = serial_rx_pkg::RX_IDLE;
		endcase
		if (!rx_active)
			st_d = serial_rx_pkg::RX_IDLE;
	end

	// two-entry fifo; head stays readable while next arrives
	always_comb begin
		mem_d  = mem_q;
		wp_d   = wp_q;
		rp_d   = rp_q;
		fcnt_d = fcnt_q;
		ovr_d  = ovr_q;
		if (accept) begin
			mem_d[wp_q] = pchar;
			wp_d        = !wp_q;
		end
		if (pop)
			rp_d = !rp_q;
		fcnt_d = fcnt_q + {1'b0, accept} - {1'b0, pop};
		// dropping receive enable also clears; a new overrun wins
		if (ovr_clr || !ctrl_q.continuous_receive_enable)
			ovr_d = 1'b0;
		if (push && !accept)
			ovr_d = 1'b1;
	end

	// transmitter: buffer frees as soon as its character is loaded
	always_comb begin
		tsh_d   = tsh_q;
		tcnt_d  = tcnt_q;
		tbits_d = tbits_q;
		tbusy_d = tbusy_q;
		txo_d   = tbusy_q ? tsh_q[0] : 1'b1;
		if (tx_load) begin
			tsh_d   = {1'b1, ctrl_q.nine_bit_mode ? tx9hold_q : 1'b1,
				txhold_q, 1'b0};
			tbits_d = ctrl_q.nine_bit_mode ? serial_rx_pkg::TX_BITS_9
				: serial_rx_pkg::TX_BITS_8;
			tcnt_d  = 4'h0;
			tbusy_d = 1'b1;
		end else if (tbusy_q && tick_q) begin
			tcnt_d = tcnt_q + 4'h1;
			if (tcnt_q == serial_rx_pkg::TICK_LAST) begin
				tsh_d   = {1'b1, tsh_q[10:1]};
				tbits_d = tbits_q - 4'h1;
				tbusy_d = tbits_q != 4'h1;
			end
		end
	end

	// datapath flops
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			brg_q   <= serial_rx_pkg::BYTE_RESET;
			tick_q  <= 1'b0;
			st_q    <= serial_rx_pkg::RX_IDLE;
			cnt_q   <= 4'h0;
			bitn_q  <= 4'h0;
			samp_q  <= 3'h7;
			rsr_q   <= 9'h000;
			line_q  <= 1'b1;
			mem_q   <= '{serial_rx_pkg::CHAR_RESET, serial_rx_pkg::CHAR_RESET};
			wp_q    <= 1'b0;
			rp_q    <= 1'b0;
			fcnt_q  <= 2'h0;
			ovr_q   <= 1'b0;
			tsh_q   <= 11'h7FF;
			tcnt_q  <= 4'h0;
			tbits_q <= 4'h0;
			tbusy_q <= 1'b0;
			txo_q   <= 1'b1;
		end else begin
			brg_q   <= brg_d;
			tick_q  <= tick_d;
			st_q    <= st_d;
			cnt_q   <= cnt_d;
			bitn_q  <= bitn_d;
			samp_q  <= samp_d;
			rsr_q   <= rsr_d;
			line_q  <= line_d;
			mem_q   <= mem_d;
			wp_q    <= wp_d;
			rp_q    <= rp_d;
			fcnt_q  <= fcnt_d;
			ovr_q   <= ovr_d;
			tsh_q   <= tsh_d;
			tcnt_q  <= tcnt_d;
			tbits_q <= tbits_d;
			tbusy_q <= tbusy_d;
			txo_q   <= txo_d;
		end
	end
endmodule // async_serial_receiver
`default_nettype wire

// File: rtl/serial_rx_pkg.sv
// constants, register map and carrier types of the serial receiver
package serial_rx_pkg;
	// register byte offsets
	localparam logic [7:0] OFF_RX_DATA   = 8'h00;
	localparam logic [7:0] OFF_TX_DATA   = 8'h04;
	localparam logic [7:0] OFF_BAUD_LOW  = 8'h08;
	localparam logic [7:0] OFF_CONTROL   = 8'h0C;
	localparam logic [7:0] OFF_STATUS    = 8'h10;
	localparam logic [7:0] OFF_IRQ_STAT  = 8'h14;
	localparam logic [7:0] OFF_IRQ_MASK  = 8'h18;
	// interrupt bits
	localparam int IRQ_RX  = 0;
	localparam int IRQ_OVR = 1;
	localparam int IRQ_FE  = 2;
	// reset values
	localparam logic [7:0] BYTE_RESET = 8'h00;
	localparam logic [2:0] IRQ_RESET  = 3'h0;
	// bus responses
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	// oversampling: 16 ticks per bit, majority on ticks 7..9
	localparam logic [3:0] TICK_LAST    = 4'hF;
	localparam logic [3:0] SAMPLE_FIRST = 4'h7;
	localparam logic [3:0] SAMPLE_LAST  = 4'h9;
	localparam logic [3:0] LAST_BIT_8   = 4'h7;
	localparam logic [3:0] LAST_BIT_9   = 4'h8;
	localparam logic [3:0] TX_BITS_8    = 4'hA;
	localparam logic [3:0] TX_BITS_9    = 4'hB;
	// control bits, high to low
	typedef struct packed {
		logic nine_bit_mode;
		logic ninth_transmit_bit;
		logic serial_port_enable;
		logic clocked_mode_select;
		logic continuous_receive_enable;
	} ctrl_type;
	localparam ctrl_type CTRL_RESET = 5'h00;
	// one received character as held in the fifo
	typedef struct packed {
		logic       framing_error;
		logic       ninth_received_bit;
		logic [7:0] data;
	} rx_char_type;
	localparam rx_char_type CHAR_RESET = 10'h000;
	// receive sequencer, one-hot
	typedef enum logic [3:0] {
		RX_IDLE  = 4'b0001,
		RX_START = 4'b0010,
		RX_DATA  = 4'b0100,
		RX_STOP  = 4'b1000
	} rx_state_type;
endpackage
